// ===== logic/cev_exception_unit.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] each source owns vector at number times four
// [RL2] reserved vector numbers are never used
// [RL3] reset wins and halts everything immediately
// [RL4] reset pin held low long enough
// [RL5] reset clears state; watchdog overflow resets too
// [RL6] on release set mask, load reset vector
// [RL7] all interrupts blocked right after reset
// [RL8] first instruction runs; software loads stack pointer
// [RL9] peripherals except transfer engine start halted
// [RL10] interrupt: push pc and flags, then vector
// [RL11] nmi outranks every other interrupt
// [RL12] trap call handled anytime: push, then vector
// [RL13] trap field 0..3 selects vectors 8..11
// [RL14] trap sets mask; user mask by mode
// [RL15] word accesses force address bit zero low
// [RL16] software keeps the stack pointer even
// [RL17] priority: reset, illegal, interrupt, trap
// [RL18] no detection after flag ops or reset
// [RL19] two-bit field picks one of two modes
// [RL20] illegal instruction vectors through 4, flags kept
module cev_exception_unit #(
  parameter int VEC_MAX = 107
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_clear_input_n,
  input wire logic wdt_overflow,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic instr_end,
  input wire logic flag_op_done,
  input wire logic illegal_op,
  input wire logic trap_exec,
  input wire logic [1:0] trap_sel,
  input wire cev_pkg::cev_irq_s irq,
  input wire logic [23:0] pc_now,
  input wire logic [7:0] ccr_now,
  input wire logic [31:0] sp_now,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output cev_pkg::cev_mem_req_s mem,
  output logic pc_load,
  output logic [23:0] pc_value,
  output logic ccr_load,
  output logic [7:0] ccr_value,
  output logic sp_load,
  output logic [31:0] sp_value,
  output logic irq_ack,
  output logic exc_active,
  output logic [15:0] module_halt_ctl,
  output logic [7:0] module_halt_ctl_a,
  output logic [7:0] sub_module_halt_ctl_b
);

  // the vector number must fit the seven-bit field and cover the irq block
  if (VEC_MAX < 64 || VEC_MAX > 127) begin : g_vec_max_check
    $error("VEC_MAX out of range");
  end

  logic wdt_rst; // one-cycle reset pulse from watchdog overflow
  logic core_rst_n; // combined asynchronous reset
  logic rel_meta; // release synchroniser, first stage
  logic rel_sync; // release synchroniser, second stage
  logic int_block; // interrupt acceptance blocked after reset
  logic bad_vec; // sticky: reserved vector was offered
  logic [1:0] irq_scheme; // irq_scheme_sel_hi, irq_scheme_sel_lo
  cev_pkg::cev_state_e state; // sequencer state
  cev_pkg::cev_kind_e kind; // exception being handled
  logic [6:0] vec_num; // vector number being handled
  logic [7:0] saved_ccr; // flags at exception entry
  logic detect; // interrupt detection point
  logic irq_take; // interrupt accepted this cycle
  logic [31:0] push_sp; // stack pointer after the push
  logic apb_setup; // setup phase of a transfer
  logic apb_wr; // write takes effect
  logic mode1; // interrupt control mode 1 selected

  // true for numbers set aside for system use or beyond the table
  function automatic logic is_reserved(input logic [6:0] v);
    logic r;
    r = 1'b0;
    if ((v >= 7'h01 && v <= 7'h03) || v == 7'h05 || v == 7'h06) begin
      r = 1'b1; // [RL2]
    end
    if ((v >= 7'h0c && v <= 7'h0f) || (v >= 7'h1e && v <= 7'h21)) begin
      r = 1'b1; // [RL2]
    end
    if (v > 7'(VEC_MAX)) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // read request of a vector entry, four bytes per number
  function automatic cev_pkg::cev_mem_req_s fetch_req(input logic [6:0] v);
    cev_pkg::cev_mem_req_s m;
    m.valid = 1'b1;
    m.write = 1'b0;
    m.addr = {15'h0000, v, 2'h0}; // [RL1]
    m.wdata = 32'h0000_0000;
    return m;
  endfunction

  // pin reset and watchdog pulse both stop all processing at once
  assign core_rst_n = presetn & chip_clear_input_n & ~wdt_rst; // [RL3] [RL5]
  // longword push: stack pointer minus four with bit zero forced low
  assign push_sp = {sp_now[31:1] - 31'h0000_0002, 1'b0}; // [RL15]
  // mode 1 when the scheme field holds its code
  assign mode1 = (irq_scheme == cev_pkg::SCHEME_MODE1); // [RL19]
  // detection at instruction end, skipped after flag ops and reset
  assign detect = (state == cev_pkg::ST_EXEC) && instr_end && !flag_op_done
    && !int_block; // [RL18] [RL7]
  // nmi ignores mask and vector field, others need a legal vector and I clear
  assign irq_take = detect && irq.req && (irq.nmi
    || (!is_reserved(irq.vec) && !ccr_now[cev_pkg::FLAG_I_POS])); // [RL11]
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;

  // watchdog overflow becomes a one-cycle internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_rst <= 1'b0;
    end else begin
      wdt_rst <= wdt_overflow; // [RL5]
    end
  end

  // reset release passes two flip-flops before the sequencer sees it
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rel_meta <= 1'b0;
      rel_sync <= 1'b0;
    end else begin
      rel_meta <= 1'b1;
      rel_sync <= rel_meta;
    end
  end

  // interrupts stay blocked until the first instruction completes
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      int_block <= 1'b1; // [RL7]
    end else if (state == cev_pkg::ST_EXEC && instr_end) begin
      int_block <= 1'b0; // [RL8]
    end
  end

  // sticky flag for a reserved vector offered; set beats clear
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      bad_vec <= 1'b0;
    end else if (detect && irq.req && !irq.nmi && is_reserved(irq.vec)) begin
      bad_vec <= 1'b1; // [RL2]
    end else if (apb_wr && paddr == cev_pkg::OFS_STATUS && pwdata[cev_pkg::ST_BADVEC_POS]) begin
      bad_vec <= 1'b0;
    end
  end

  // exception sequencer: save, fetch vector, load pc and flags
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state <= cev_pkg::ST_HOLD;
      kind <= cev_pkg::K_RESET;
      vec_num <= cev_pkg::VEC_RESET;
      saved_ccr <= cev_pkg::RST_CCR;
      mem <= '0;
      pc_load <= 1'b0;
      pc_value <= 24'h00_0000;
      ccr_load <= 1'b0;
      ccr_value <= cev_pkg::RST_CCR; // [RL6]
      sp_load <= 1'b0;
      sp_value <= 32'h0000_0000;
      irq_ack <= 1'b0;
      exc_active <= 1'b1;
    end else begin
      pc_load <= 1'b0;
      ccr_load <= 1'b0;
      sp_load <= 1'b0;
      irq_ack <= 1'b0;
      case (state)
        cev_pkg::ST_HOLD: begin
          // reset handling: fetch vector 0 once the release is seen
          if (rel_sync) begin
            mem <= fetch_req(cev_pkg::VEC_RESET); // [RL6]
            state <= cev_pkg::ST_FETCH;
          end
        end
        cev_pkg::ST_EXEC: begin
          // fixed priority among simultaneous events
          if (instr_end && (illegal_op || irq_take || trap_exec)) begin
            mem.valid <= 1'b1;
            mem.write <= 1'b1;
            mem.addr <= push_sp[23:0]; // [RL15]
            mem.wdata <= {ccr_now, pc_now}; // [RL10]
            saved_ccr <= ccr_now;
            exc_active <= 1'b1;
            state <= cev_pkg::ST_SAVE;
            if (illegal_op) begin
              kind <= cev_pkg::K_ILL; // [RL17] [RL20]
              vec_num <= cev_pkg::VEC_ILLEGAL;
            end else if (irq_take) begin
              kind <= cev_pkg::K_IRQ; // [RL10]
              vec_num <= irq.nmi ? cev_pkg::VEC_NMI : irq.vec; // [RL11]
              irq_ack <= 1'b1;
            end else begin
              kind <= cev_pkg::K_TRAP; // [RL12]
              vec_num <= cev_pkg::VEC_TRAP_BASE + {5'h00, trap_sel}; // [RL13]
            end
          end
        end
        cev_pkg::ST_SAVE: begin
          // push done: commit stack pointer, then read the vector
          if (mem_ack) begin
            sp_load <= 1'b1;
            sp_value <= push_sp; // [RL16]
            mem <= fetch_req(vec_num); // [RL1] [RL10]
            state <= cev_pkg::ST_FETCH;
          end
        end
        cev_pkg::ST_FETCH: begin
          // vector read: jump and load the flags; global mask set unless illegal
          if (mem_ack) begin
            mem.valid <= 1'b0;
            pc_load <= 1'b1;
            pc_value <= mem_rdata[23:0]; // [RL6] [RL12]
            ccr_load <= 1'b1;
            exc_active <= 1'b0;
            state <= cev_pkg::ST_EXEC;
            case (kind)
              cev_pkg::K_RESET: begin
                ccr_value <= cev_pkg::RST_CCR; // [RL6]
              end
              cev_pkg::K_ILL: begin
                ccr_value <= saved_ccr; // [RL20]
              end
              default: begin
                // global mask set; user mask set only in mode 1
                ccr_value <= saved_ccr;
                ccr_value[cev_pkg::FLAG_I_POS] <= 1'b1; // [RL14]
                if (mode1) begin
                  ccr_value[cev_pkg::FLAG_UI_POS] <= 1'b1; // [RL14]
                end
              end
            endcase
          end
        end
        default: begin
          state <= cev_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // configuration and halt control registers, written by software
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      irq_scheme <= cev_pkg::SCHEME_MODE0;
      module_halt_ctl <= cev_pkg::RST_HALT; // [RL9]
      module_halt_ctl_a <= cev_pkg::RST_HALT_A; // [RL9]
      sub_module_halt_ctl_b <= cev_pkg::RST_SUB_HALT_B; // [RL9]
    end else if (apb_wr) begin
      case (paddr)
        cev_pkg::OFS_SYSCFG: begin
          // only the two legal mode codes are accepted
          if (pwdata[1:0] == cev_pkg::SCHEME_MODE0 || pwdata[1:0] == cev_pkg::SCHEME_MODE1) begin
            irq_scheme <= pwdata[1:0]; // [RL19]
          end
        end
        cev_pkg::OFS_HALT: begin
          module_halt_ctl <= pwdata[15:0];
        end
        cev_pkg::OFS_HALT_A: begin
          module_halt_ctl_a <= pwdata[7:0];
        end
        cev_pkg::OFS_SUB_HALT_B: begin
          sub_module_halt_ctl_b <= pwdata[7:0];
        end
        default: irq_scheme <= irq_scheme;
      endcase
    end
  end

  // apb answer: one wait-free access phase, read data set up in setup
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
        case (paddr)
          cev_pkg::OFS_SYSCFG: begin
            prdata[1:0] <= irq_scheme;
          end
          cev_pkg::OFS_HALT: begin
            prdata[15:0] <= module_halt_ctl;
          end
          cev_pkg::OFS_HALT_A: begin
            prdata[7:0] <= module_halt_ctl_a;
          end
          cev_pkg::OFS_SUB_HALT_B: begin
            prdata[7:0] <= sub_module_halt_ctl_b;
          end
          cev_pkg::OFS_STATUS: begin
            prdata[cev_pkg::ST_ACTIVE_POS] <= exc_active;
            prdata[cev_pkg::ST_BLOCK_POS] <= int_block;
            prdata[cev_pkg::ST_BADVEC_POS] <= bad_vec;
            prdata[cev_pkg::ST_VEC_LSB +: 7] <= vec_num;
          end
          default: begin
            // unmapped address answers with an error
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // reset release leads to a read of entry zero next cycle
  a_reset_vector_read: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_HOLD && rel_sync) |=> (mem.valid && !mem.write
    && mem.addr == 24'h00_0000)) // [RL6]
    else $error("reset did not fetch vector zero");
  a_irq_block_reset: assert property (@(posedge pclk) disable iff (!core_rst_n)
    irq_ack |-> !$past(int_block)) // [RL7]
    else $error("interrupt taken while blocked after reset");
  a_push_even_first: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_SAVE) |-> (mem.valid && mem.write && !mem.addr[0])) // [RL10]
    else $error("stack push missing or odd address");
  a_trap_vector_sel: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_EXEC && instr_end && !illegal_op && !irq_take && trap_exec)
    |=> (vec_num == 7'h08 + {5'h00, $past(trap_sel)})) // [RL13]
    else $error("trap vector not eight plus field");
  a_trap_ccr_flags: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (pc_load && kind == cev_pkg::K_TRAP) |-> (ccr_value[7]
    && ccr_value[6] == (mode1 | saved_ccr[6]))) // [RL14]
    else $error("trap mask flags wrong");

  a_fetch_not_rsvd: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_FETCH && mem.valid) |-> (!is_reserved(vec_num)
    && mem.addr == {15'h0000, vec_num, 2'h0})) // [RL1]
    else $error("vector fetch from reserved or wrong entry");

  a_illegal_first: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_EXEC && instr_end && illegal_op)
    |=> (vec_num == 7'h04 && !irq_ack) ##1 (state == cev_pkg::ST_SAVE)) // [RL17]
    else $error("illegal instruction lost priority");

  a_no_detect_flag: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_EXEC && instr_end && flag_op_done) |=> !irq_ack) // [RL18]
    else $error("interrupt taken after flag operation");

  a_nmi_always_taken: assert property (@(posedge pclk) disable iff (!core_rst_n)
    (state == cev_pkg::ST_EXEC && instr_end && !illegal_op && !flag_op_done
    && !int_block && irq.req && irq.nmi) |=> (irq_ack && vec_num == 7'h07)) // [RL11]
    else $error("nmi not accepted");

endmodule

// ===== logic/cev_pkg.sv
package cev_pkg;

  // vector numbers of the fixed exception sources
  localparam logic [6:0] VEC_RESET = 7'h00;
  localparam logic [6:0] VEC_ILLEGAL = 7'h04;
  localparam logic [6:0] VEC_NMI = 7'h07;
  localparam logic [6:0] VEC_TRAP_BASE = 7'h08;
  localparam logic [6:0] VEC_LAST = 7'h6b;

  // condition flags bit positions
  localparam int FLAG_I_POS = 7;
  localparam int FLAG_UI_POS = 6;
  // flags value loaded by reset: global mask set
  localparam logic [7:0] RST_CCR = 8'h80;

  // register byte offsets
  localparam logic [7:0] OFS_SYSCFG = 8'h00;
  localparam logic [7:0] OFS_HALT = 8'h04;
  localparam logic [7:0] OFS_HALT_A = 8'h08;
  localparam logic [7:0] OFS_SUB_HALT_B = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // interrupt scheme field codes
  localparam logic [1:0] SCHEME_MODE0 = 2'h0;
  localparam logic [1:0] SCHEME_MODE1 = 2'h2;

  // halt control reset values: all halted except the transfer engine
  localparam int XFER_ENGINE_POS = 14;
  localparam logic [15:0] RST_HALT = 16'hbfff;
  localparam logic [7:0] RST_HALT_A = 8'hff;
  localparam logic [7:0] RST_SUB_HALT_B = 8'hff;

  // status register field positions
  localparam int ST_ACTIVE_POS = 0;
  localparam int ST_BLOCK_POS = 1;
  localparam int ST_BADVEC_POS = 8;
  localparam int ST_VEC_LSB = 16;

  // memory request to the core bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } cev_mem_req_s;

  // interrupt request from the interrupt controller
  typedef struct packed {
    logic req;
    logic nmi;
    logic [6:0] vec;
  } cev_irq_s;

  // sequencer states
  typedef enum logic [1:0] {ST_HOLD, ST_EXEC, ST_SAVE, ST_FETCH} cev_state_e;

  // kind of exception under way
  typedef enum logic [1:0] {K_RESET, K_ILL, K_IRQ, K_TRAP} cev_kind_e;

endpackage

// ===== testbench/cev_core_model.sv
`timescale 1ns/1ps
// memory side of the core: answers pushes and vector reads after a chosen lag
module cev_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire cev_pkg::cev_mem_req_s mem,
  input wire logic [1:0] lag,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic [23:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [23:0] rd_addr,
  output logic [7:0] n_rd
);
  logic [1:0] wait_cnt; // cycles spent on the open request

  // one-cycle ack; read data is only meaningful beside the ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt <= 2'h0;
      wr_addr <= 24'h0;
      wr_data <= 32'h0;
      rd_addr <= 24'h0;
      n_rd <= 8'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // stale data never looks valid
    end else if (mem.valid && wait_cnt != lag) begin
      wait_cnt <= wait_cnt + 2'h1; // slow answer
    end else if (mem.valid) begin
      mem_ack <= 1'b1;
      wait_cnt <= 2'h0;
      if (mem.write) begin
        wr_addr <= mem.addr;
        wr_data <= mem.wdata;
      end else begin
        rd_addr <= mem.addr;
        n_rd <= n_rd + 8'h1;
        mem_rdata <= {8'h00, 24'hc00000 | mem.addr}; // vector entry content
      end
    end
  end
endmodule

// ===== testbench/cpu_exception_vectoring_tb.sv
`timescale 1ns/1ps
module cpu_exception_vectoring_tb;
  localparam logic [6:0] NONE = 7'h7f; // no handling expected
  logic pclk, presetn, chip_clear_input_n, wdt_overflow, psel, penable, pwrite;
  logic [7:0] paddr, ccr_now, ccr_value, module_halt_ctl_a, sub_module_halt_ctl_b, n_rd, cc;
  logic [31:0] pwdata, prdata, sp_now, mem_rdata, sp_value, wr_data, rd, sp;
  logic pready, pslverr, instr_end, flag_op_done, illegal_op, trap_exec, mem_ack, err;
  logic pc_load, ccr_load, sp_load, irq_ack, exc_active;
  logic [1:0] trap_sel, lag;
  logic [23:0] pc_now, pc_value, wr_addr, rd_addr, pc_seen;
  logic [7:0] ccr_seen;
  logic [31:0] sp_seen;
  logic [15:0] module_halt_ctl;
  logic [6:0] v;
  cev_pkg::cev_irq_s irq;
  cev_pkg::cev_mem_req_s mem;
  int n_fail, checks, n_pc, n_ack, m, s, k, i;
  int seed;

  cev_exception_unit i_cev_exception_unit (.pclk(pclk), .presetn(presetn),
    .chip_clear_input_n(chip_clear_input_n), .wdt_overflow(wdt_overflow), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .instr_end(instr_end), .flag_op_done(flag_op_done),
    .illegal_op(illegal_op), .trap_exec(trap_exec), .trap_sel(trap_sel), .irq(irq),
    .pc_now(pc_now), .ccr_now(ccr_now), .sp_now(sp_now), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem(mem), .pc_load(pc_load), .pc_value(pc_value),
    .ccr_load(ccr_load), .ccr_value(ccr_value), .sp_load(sp_load), .sp_value(sp_value),
    .irq_ack(irq_ack), .exc_active(exc_active), .module_halt_ctl(module_halt_ctl),
    .module_halt_ctl_a(module_halt_ctl_a), .sub_module_halt_ctl_b(sub_module_halt_ctl_b));
  cev_core_model i_cev_core_model (.pclk(pclk), .presetn(presetn & chip_clear_input_n),
    .mem(mem), .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .n_rd(n_rd));

  // 10 mhz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // capture the one-cycle load and ack pulses
  always @(posedge pclk) begin
    if (pc_load === 1'b1) begin
      n_pc <= n_pc + 1;
      pc_seen <= pc_value;
      ccr_seen <= ccr_value;
    end
    if (sp_load === 1'b1) sp_seen <= sp_value;
    if (irq_ack === 1'b1) n_ack <= n_ack + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a bounded wait ran out
  task automatic stall();
    $display("ERROR wait expected done seen hang");
    n_fail++;
    results();
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 20 && pready !== 1'b1; j++) @(posedge pclk);
    if (j == 20) stall();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_pc(input int np0);
    int j;
    for (j = 0; j < 60 && n_pc == np0; j++) @(posedge pclk);
    if (j == 60) stall();
  endtask

  // end an instruction with the given events and judge the handling
  task automatic go(input logic ill, input logic tr, input logic [1:0] sel,
      input cev_pkg::cev_irq_s rq, input logic fl, input logic [6:0] ev,
      input logic [7:0] cx, input logic aq);
    int np0, na0, nr0;
    logic [23:0] pcv;
    pcv = 24'($random(seed));
    np0 = n_pc;
    na0 = n_ack;
    nr0 = n_rd;
    @(posedge pclk);
    {instr_end, illegal_op, trap_exec, flag_op_done} <= {1'b1, ill, tr, fl};
    {trap_sel, irq, pc_now, ccr_now, sp_now} <= {sel, rq, pcv, cc, sp};
    lag <= 2'($random(seed));
    @(posedge pclk);
    {instr_end, illegal_op, trap_exec, flag_op_done, irq} <= '0;
    if (ev == NONE) begin
      repeat (6) @(posedge pclk);
      chk("idle reads", n_rd, nr0);
      chk("idle busy", exc_active, 1'b0);
      chk("idle ack", n_ack - na0, 32'h0);
    end else begin
      wait_pc(np0);
      chk("push addr", wr_addr, (sp - 32'h4) & 32'h00fffffe);
      chk("push data", wr_data, {cc, pcv});
      chk("vector addr", rd_addr, {ev, 2'b00});
      chk("new pc", pc_seen, 24'hc00000 | {ev, 2'b00});
      chk("flags", ccr_seen, cx);
      chk("ack", n_ack - na0, aq);
      if (!sp[0]) chk("sp", sp_seen, sp - 32'h4);
    end
  endtask

  initial begin
    seed = 32'hb0b7;
    {presetn, wdt_overflow, psel, penable, pwrite, paddr, pwdata, instr_end} = '0;
    {flag_op_done, illegal_op, trap_exec, trap_sel, irq, pc_now, ccr_now, sp_now} = '0;
    {chip_clear_input_n, lag, n_fail, checks, n_pc, n_ack} = {1'b1, 2'h0, 128'h0};
    repeat (2) @(posedge pclk);
    chk("reset busy", exc_active, 1'b1);
    chk("reset flags", ccr_value, 8'h80);
    chk("halt", module_halt_ctl, 16'hbfff);
    chk("halt a", {module_halt_ctl_a, sub_module_halt_ctl_b}, 16'hffff);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_pc(0);
    chk("reset vector", rd_addr, 24'h000000);
    chk("reset pc", pc_seen, 24'hc00000);
    chk("reset mask", ccr_value[7], 1'b1);
    done("reset");
    apb(1'b0, cev_pkg::OFS_HALT, 32'h0);
    chk("halt read", rd, 32'h0000bfff);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", err, 1'b1);
    apb(1'b1, cev_pkg::OFS_SYSCFG, 32'h1);
    apb(1'b0, cev_pkg::OFS_SYSCFG, 32'h0);
    chk("scheme", rd[1:0], 2'h0);
    done("registers");
    sp = 32'h1000;
    cc = 8'h00;
    go(1'b0, 1'b0, 2'h0, {1'b1, 1'b1, 7'h10}, 1'b0, NONE, 8'h0, 1'b0);
    done("first instruction");
    for (m = 0; m < 2; m++) begin
      apb(1'b1, cev_pkg::OFS_SYSCFG, m ? 32'h2 : 32'h0);
      for (s = 0; s < 4; s++) begin
        cc = 8'($random(seed));
        sp = ($random(seed) & 32'hfffffe) | (s == 3); // odd pointer on the last one
        go(1'b0, 1'b1, 2'(s), '0, 1'b0, 7'h8 + 7'(s), cc | (m ? 8'hc0 : 8'h80),
          1'b0);
      end
    end
    done("traps");
    sp = 32'h2000;
    for (k = 0; k < 6; k++) begin
      v = 7'h10 + 7'({$random(seed)} % 92);
      if (v >= 30 && v <= 33) v = v + 7'h4;
      cc = 8'($random(seed)) & 8'h7f;
      go(1'b0, 1'b0, 2'h0, {1'b1, 1'b0, v}, 1'b0, v, cc | 8'hc0, 1'b1);
    end
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 7'h5 : (i == 1) ? 7'h1e : 7'h21;
      go(1'b0, 1'b0, 2'h0, {1'b1, 1'b0, v}, 1'b0, NONE, 8'h0, 1'b0);
    end
    // refused vector leaves the sticky flag; a one written clears it
    apb(1'b0, cev_pkg::OFS_STATUS, 32'h0);
    chk("bad vec", rd[8], 1'b1);
    apb(1'b1, cev_pkg::OFS_STATUS, 32'h100);
    apb(1'b0, cev_pkg::OFS_STATUS, 32'h0);
    chk("bad vec clear", rd[8], 1'b0);
    cc = 8'h85;
    go(1'b0, 1'b0, 2'h0, {1'b1, 1'b1, 7'h55}, 1'b0, 7'h7, cc | 8'hc0, 1'b1);
    // nmi with a reserved number in the vector field still goes through 7
    go(1'b0, 1'b0, 2'h0, {1'b1, 1'b1, 7'h1f}, 1'b0, 7'h7, cc | 8'hc0, 1'b1);
    go(1'b0, 1'b0, 2'h0, {1'b1, 1'b0, 7'h14}, 1'b0, NONE, 8'h0, 1'b0);
    cc = 8'h05;
    go(1'b0, 1'b0, 2'h0, {1'b1, 1'b1, 7'h14}, 1'b1, NONE, 8'h0, 1'b0);
    done("interrupts");
    go(1'b1, 1'b1, 2'h2, {1'b1, 1'b1, 7'h14}, 1'b0, 7'h4, cc, 1'b0);
    go(1'b0, 1'b1, 2'h1, {1'b1, 1'b0, 7'h28}, 1'b0, 7'h28, cc | 8'hc0, 1'b1);
    done("priority");
    apb(1'b1, cev_pkg::OFS_HALT, 32'h0);
    @(posedge pclk);
    chk("halt cleared", module_halt_ctl, 16'h0);
    k = n_pc;
    wdt_overflow <= 1'b1;
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    wait_pc(k);
    chk("wdt vector", rd_addr, 24'h000000);
    chk("wdt halt", module_halt_ctl, 16'hbfff);
    done("watchdog");
    @(posedge pclk);
    {instr_end, trap_exec, lag} <= {2'b11, 2'h3};
    @(posedge pclk);
    {instr_end, trap_exec} <= 2'b00;
    for (i = 0; i < 20 && mem.valid !== 1'b1; i++) @(posedge pclk);
    if (i == 20) stall();
    chip_clear_input_n <= 1'b0;
    @(negedge pclk);
    chk("abort", {mem.valid, exc_active}, 2'b01);
    k = n_pc;
    repeat (20) @(posedge pclk);
    chip_clear_input_n <= 1'b1;
    wait_pc(k);
    chk("restart", pc_seen, 24'hc00000);
    done("pin reset");
    results();
  end
endmodule
